// File: inc/bss_pkg.sv
// Constants for the buck set point register bank
package bss_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] BSS_ADDR_NORMAL  = 8'h35;
	localparam logic [7:0] BSS_ADDR_STANDBY = 8'h36;
	localparam logic [7:0] BSS_ADDR_SLEEP   = 8'h37;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int         BSS_CODE_LSB   = 0;
	localparam int         BSS_CODE_MSB   = 5;
	localparam int         BSS_RANGE_BIT  = 6;
	localparam int         BSS_UNUSED_BIT = 7;
	localparam logic [5:0] BSS_CODE_RST   = 6'h00;
	localparam logic       BSS_RANGE_RST  = 1'b0;

	// ----------------------------------------------------------------
	// Voltage mapping in millivolts
	// ----------------------------------------------------------------
	localparam logic [11:0] BSS_LOW_BASE_MV  = 12'h190;
	localparam logic [11:0] BSS_LOW_STEP_MV  = 12'h019;
	localparam logic [11:0] BSS_HIGH_BASE_MV = 12'h320;
	localparam logic [11:0] BSS_HIGH_STEP_MV = 12'h032;
	localparam logic [11:0] BSS_MIN_OK_MV    = 12'h258;
	localparam logic [5:0]  BSS_HIGH_MAX_CODE = 6'h32;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BSS_MODE_NORMAL  = 2'b00,
		BSS_MODE_STANDBY = 2'b01,
		BSS_MODE_SLEEP   = 2'b10
	} bss_mode_t;

endpackage : bss_pkg

// File: rtl/bss_setpoint_field.sv
// One host-writable 6-bit set point field
`timescale 1ns/1ns
`default_nettype none
module bss_setpoint_field
	import bss_pkg::*;
#(
	parameter logic [7:0] ADDR = 8'h00
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Write port
	input  wire logic       wr,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	// Field
	output logic      [5:0] field_q
);

	logic [5:0] field_d;
	wire        hit = wr && (addr == ADDR);

	assign field_d = hit ? wdata[BSS_CODE_MSB:BSS_CODE_LSB] : field_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			field_q <= BSS_CODE_RST;
		end else begin
			field_q <= field_d;
		end
	end

endmodule : bss_setpoint_field
`default_nettype wire

// File: rtl/bss_setpoint_select.sv
// Buck set point bank: three mode fields, shared range bit, active code out
`timescale 1ns/1ns
`default_nettype none
module bss_setpoint_select
	import bss_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        ARST_N,
	// Register port
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	// Range configuration
	input  wire logic        CFG_DEFAULT_RANGE,
	input  wire logic        CFG_OTP_PROGRAMMED,
	input  wire logic        CFG_OTP_RANGE,
	// Operating mode
	input  wire logic [1:0]  MODE,
	// Regulator target
	output logic      [6:0]  ACTIVE_CODE,
	output logic      [11:0] ACTIVE_MV,
	output logic             CODE_RESERVED,
	output logic             MV_UNSUPPORTED,
	output logic             RANGE_LOADED
);

	// ----------------------------------------------------------------
	// Range bit capture
	// ----------------------------------------------------------------
	logic range_q;
	logic range_d;
	logic loaded_q;
	logic cfg_range;

	assign cfg_range = CFG_OTP_PROGRAMMED ? CFG_OTP_RANGE : CFG_DEFAULT_RANGE;
	assign range_d   = loaded_q ? range_q : cfg_range;

	// Straps caught after release, never under reset
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			range_q  <= BSS_RANGE_RST;
			loaded_q <= 1'b0;
		end else begin
			range_q  <= range_d;
			loaded_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Set point fields
	// ----------------------------------------------------------------
	logic [5:0] normal_setpoint_code;
	logic [5:0] standby_setpoint_code;
	logic [5:0] sleep_setpoint_code;

	bss_setpoint_field #(.ADDR(BSS_ADDR_NORMAL)) u_normal (
		.clk     (MCLK),
		.arst_n  (ARST_N),
		.wr      (REG_WR),
		.addr    (REG_ADDR),
		.wdata   (REG_WDATA),
		.field_q (normal_setpoint_code)
	);

	bss_setpoint_field #(.ADDR(BSS_ADDR_STANDBY)) u_standby (
		.clk     (MCLK),
		.arst_n  (ARST_N),
		.wr      (REG_WR),
		.addr    (REG_ADDR),
		.wdata   (REG_WDATA),
		.field_q (standby_setpoint_code)
	);

	bss_setpoint_field #(.ADDR(BSS_ADDR_SLEEP)) u_sleep (
		.clk     (MCLK),
		.arst_n  (ARST_N),
		.wr      (REG_WR),
		.addr    (REG_ADDR),
		.wdata   (REG_WDATA),
		.field_q (sleep_setpoint_code)
	);

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [5:0] rd_code;
	wire        rd_normal  = (REG_ADDR == BSS_ADDR_NORMAL);
	wire        rd_standby = (REG_ADDR == BSS_ADDR_STANDBY);
	wire        rd_sleep   = (REG_ADDR == BSS_ADDR_SLEEP);
	wire        rd_hit     = rd_normal || rd_standby || rd_sleep;

	assign rd_code = rd_normal  ? normal_setpoint_code  :
	                 rd_standby ? standby_setpoint_code :
	                 rd_sleep   ? sleep_setpoint_code   : 6'h00;
	// One range bit in all three
	assign rdata_d = rd_hit ? {1'b0, range_q, rd_code} : 8'h00;

	// Unmapped addresses read zero
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;

	// ----------------------------------------------------------------
	// Active set point
	// ----------------------------------------------------------------
	bss_mode_t  mode;
	logic [5:0] sel_code;
	logic [11:0] step_mv;
	logic [11:0] mv_d;
	logic [6:0] code_q;
	logic [11:0] mv_q;
	logic       resv_q;
	logic       unsup_q;

	assign mode = bss_mode_t'(MODE);

	always_comb begin
		unique case (mode)
			BSS_MODE_NORMAL:  sel_code = normal_setpoint_code;
			BSS_MODE_STANDBY: sel_code = standby_setpoint_code;
			BSS_MODE_SLEEP:   sel_code = sleep_setpoint_code;
			default:          sel_code = normal_setpoint_code;
		endcase
	end

	assign step_mv = range_q ? BSS_HIGH_STEP_MV : BSS_LOW_STEP_MV;
	assign mv_d    = 12'((range_q ? BSS_HIGH_BASE_MV : BSS_LOW_BASE_MV)
	                 + 12'({6'h00, sel_code} * step_mv));

	// Flags only; the host still owns code choice
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			code_q  <= {BSS_RANGE_RST, BSS_CODE_RST};
			mv_q    <= BSS_LOW_BASE_MV;
			resv_q  <= 1'b0;
			unsup_q <= 1'b1;
		end else begin
			code_q  <= {range_q, sel_code};
			mv_q    <= mv_d;
			resv_q  <= range_q && (sel_code > BSS_HIGH_MAX_CODE);
			unsup_q <= (mv_d <= BSS_MIN_OK_MV);
		end
	end

	assign ACTIVE_CODE    = code_q;
	assign ACTIVE_MV      = mv_q;
	assign CODE_RESERVED  = resv_q;
	assign MV_UNSUPPORTED = unsup_q;
	assign RANGE_LOADED   = loaded_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_range_frozen;
		@(posedge MCLK) disable iff (!ARST_N)
		loaded_q |=> $stable(range_q) && loaded_q;
	endproperty
	a_range_frozen: assert property (p_range_frozen)
		else $error("range bit changed after load");

	property p_range_source;
		@(posedge MCLK) disable iff (!ARST_N)
		!loaded_q |=> range_q == $past(cfg_range);
	endproperty
	a_range_source: assert property (p_range_source)
		else $error("range bit not taken from configuration");

	property p_low_map;
		@(posedge MCLK) disable iff (!ARST_N)
		!range_q |=> ACTIVE_MV == 12'(BSS_LOW_BASE_MV + BSS_LOW_STEP_MV * {6'h00, $past(sel_code)});
	endproperty
	a_low_map: assert property (p_low_map)
		else $error("low range voltage wrong");

	property p_high_map;
		@(posedge MCLK) disable iff (!ARST_N)
		range_q |=> ACTIVE_MV == 12'(BSS_HIGH_BASE_MV + BSS_HIGH_STEP_MV * {6'h00, $past(sel_code)});
	endproperty
	a_high_map: assert property (p_high_map)
		else $error("high range voltage wrong");

	property p_mode_sleep;
		@(posedge MCLK) disable iff (!ARST_N)
		MODE == BSS_MODE_SLEEP |=> ACTIVE_CODE == {$past(range_q), $past(sleep_setpoint_code)};
	endproperty
	a_mode_sleep: assert property (p_mode_sleep)
		else $error("sleep mode did not apply sleep field");

	sequence s_standby_write;
		REG_WR && REG_ADDR == BSS_ADDR_STANDBY;
	endsequence
	sequence s_standby_read;
		!REG_WR && REG_ADDR == BSS_ADDR_STANDBY;
	endsequence
	property p_standby_readback;
		@(posedge MCLK) disable iff (!ARST_N)
		s_standby_write ##1 s_standby_read |=>
			REG_RDATA == {1'b0, $past(range_q), $past(REG_WDATA[5:0], 2)};
	endproperty
	a_standby_readback: assert property (p_standby_readback)
		else $error("standby read back wrong");

	property p_write_code_only;
		@(posedge MCLK) disable iff (!ARST_N)
		// Range load on the first edge is not a write effect
		loaded_q && REG_WR && REG_ADDR == BSS_ADDR_NORMAL |=>
			normal_setpoint_code == $past(REG_WDATA[5:0]) && $stable(range_q);
	endproperty
	a_write_code_only: assert property (p_write_code_only)
		else $error("normal write did not store code only");

	property p_unsupported;
		@(posedge MCLK) disable iff (!ARST_N)
		MV_UNSUPPORTED == (ACTIVE_MV <= BSS_MIN_OK_MV);
	endproperty
	a_unsupported: assert property (p_unsupported)
		else $error("unsupported flag disagrees with voltage");

endmodule : bss_setpoint_select
`default_nettype wire

// File: bench/bss_host.sv
// Host model driving the set point register port
`timescale 1ns/1ns
`default_nettype none
module bss_host (
	// Clock and read data
	input  wire logic       MCLK,
	input  wire logic [7:0] REG_RDATA,
	// Write port
	output var  logic       REG_WR,
	output var  logic [7:0] REG_ADDR,
	output var  logic [7:0] REG_WDATA
);
	initial begin
		REG_WR = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		REG_WR = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(posedge MCLK);
		#1;
		REG_WR = 1'b0;
		// Released data shows inverse, not a stale copy
		REG_WDATA = ~d;
		// Idle cycle so a next write never re-raises the strobe at once
		@(posedge MCLK);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		REG_ADDR = a;
		@(posedge MCLK);
		#1;
		d = REG_RDATA;
	endtask : rd
endmodule : bss_host
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the set point bank
`timescale 1ns/1ns
`default_nettype none
module tb
	import bss_pkg::*;
;
	logic        mclk = 1'b0;
	logic        arst_n;
	logic        cfg_def;
	logic        cfg_otp_p;
	logic        cfg_otp_r;
	logic [1:0]  mode = 2'b00;
	logic [7:0]  rd_v;
	wire         reg_wr;
	wire  [7:0]  reg_addr;
	wire  [7:0]  reg_wdata;
	wire  [7:0]  reg_rdata;
	wire  [6:0]  act_code;
	wire  [11:0] act_mv;
	wire         code_rsv;
	wire         mv_uns;
	wire         rng_ld;
	int          mismatches = 0;
	int          num_checks = 0;

	always #50 mclk = ~mclk;

	bss_host host (.MCLK(mclk), .REG_RDATA(reg_rdata), .REG_WR(reg_wr),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
	bss_setpoint_select uut (.MCLK(mclk), .ARST_N(arst_n), .REG_WR(reg_wr),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.CFG_DEFAULT_RANGE(cfg_def), .CFG_OTP_PROGRAMMED(cfg_otp_p),
		.CFG_OTP_RANGE(cfg_otp_r), .MODE(mode), .ACTIVE_CODE(act_code),
		.ACTIVE_MV(act_mv), .CODE_RESERVED(code_rsv), .MV_UNSUPPORTED(mv_uns),
		.RANGE_LOADED(rng_ld));

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Config held steady across release; range is captured there
	task automatic do_reset(input logic d, input logic p, input logic r);
		arst_n = 1'b0;
		cfg_def = d;
		cfg_otp_p = p;
		cfg_otp_r = r;
		repeat (5) @(posedge mclk);
		#1;
		chk(12'(rng_ld), 12'h000);
		chk(12'(act_code), 12'h000);
		arst_n = 1'b1;
		@(posedge mclk);
		#1;
	endtask : do_reset

	task automatic t_reset;
		do_reset(1'b0, 1'b0, 1'b0);
		chk(12'(rng_ld), 12'h001);
		chk(act_mv, 12'h190);
		chk(12'(mv_uns), 12'h001);
		host.rd(BSS_ADDR_NORMAL, rd_v);
		chk(12'(rd_v), 12'h000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_low;
		host.wr(BSS_ADDR_NORMAL, 8'hd5);
		host.wr(8'h38, 8'h3f);
		chk(12'(act_code), 12'h015);
		chk(act_mv, 12'h39d);
		host.rd(BSS_ADDR_NORMAL, rd_v);
		chk(12'(rd_v), 12'h015);
		host.rd(8'h38, rd_v);
		chk(12'(rd_v), 12'h000);
		$display("test low range done");
	endtask : t_low

	task automatic t_modes;
		host.wr(BSS_ADDR_STANDBY, 8'h20);
		host.wr(BSS_ADDR_SLEEP, 8'h3f);
		host.rd(BSS_ADDR_STANDBY, rd_v);
		chk(12'(rd_v), 12'h020);
		mode = 2'b01;
		@(posedge mclk);
		#1;
		chk(act_mv, 12'h4b0);
		mode = 2'b10;
		@(posedge mclk);
		#1;
		chk(act_mv, 12'h7b7);
		mode = 2'b11;
		@(posedge mclk);
		#1;
		chk(act_mv, 12'h39d);
		$display("test modes done");
	endtask : t_modes

	task automatic t_high;
		do_reset(1'b0, 1'b1, 1'b1);
		mode = 2'b10;
		host.wr(BSS_ADDR_SLEEP, 8'h32);
		@(posedge mclk);
		#1;
		chk(12'(act_code), 12'h072);
		chk(act_mv, 12'hce4);
		chk(12'(code_rsv), 12'h000);
		chk(12'(mv_uns), 12'h000);
		host.rd(BSS_ADDR_STANDBY, rd_v);
		chk(12'(rd_v), 12'h040);
		host.wr(BSS_ADDR_NORMAL, 8'h18);
		host.rd(BSS_ADDR_NORMAL, rd_v);
		chk(12'(rd_v), 12'h058);
		host.wr(BSS_ADDR_SLEEP, 8'h33);
		chk(12'(act_code), 12'h073);
		chk(12'(code_rsv), 12'h001);
		chk(act_mv, 12'hd16);
		do_reset(1'b1, 1'b1, 1'b0);
		host.rd(BSS_ADDR_NORMAL, rd_v);
		chk(12'(rd_v), 12'h000);
		do_reset(1'b1, 1'b0, 1'b0);
		cfg_def = 1'b0;
		host.rd(BSS_ADDR_NORMAL, rd_v);
		chk(12'(rd_v), 12'h040);
		$display("test high range done");
	endtask : t_high

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		t_reset();
		t_low();
		t_modes();
		t_high();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
